// File: inc/converter_control_cfg.svh
`ifndef CONVERTER_CONTROL_CFG_SVH
`define CONVERTER_CONTROL_CFG_SVH

// Register offsets (byte addresses on the serial register port)
`define CONV0_LIMIT_SLEW_ADDR 8'h03
`define CONV1_CONTROL_ADDR 8'h04
`define CONV1_LIMIT_SLEW_ADDR 8'h05
`define CONV0_VOLTAGE_SET_ADDR 8'h06
`define CONV1_VOLTAGE_SET_ADDR 8'h07
`define LINREG0_CONTROL_ADDR 8'h08
`define LINREG1_CONTROL_ADDR 8'h09

// Field positions
`define TURN_ON_BIT 0
`define PIN_GATING_BIT 1
`define DISCHARGE_BIT 2
`define FORCE_PW_BIT 3
`define RAMP_LSB 0
`define LIMIT_LSB 3

// Reset values: discharge bits set, all else zero
`define CONTROL_RESET 8'h04
`define LIMIT_SLEW_RESET 8'h00
`define VOLTAGE_RESET 8'h00

// Code range limits
`define LIMIT_MAX_CODE 3'h5
`define RAMP_MIN_CODE 3'h2
`define VOLT_MIN_CODE 8'h14

`endif

// File: inc/converter_control_pkg.sv
package converter_control_pkg;
	typedef struct packed {
		logic write;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	typedef struct packed {
		logic [2:0] current_limit;
		logic [2:0] ramp_code;
		logic [7:0] voltage_code;
		logic force_pulse_width;
		logic discharge_on;
		logic enable;
		logic limit_code_ok;
		logic ramp_code_ok;
		logic voltage_code_ok;
	} conv_ctrl_t;

	typedef struct packed {
		logic discharge_on;
		logic enable;
	} lin_ctrl_t;
endpackage

// File: hdl/pin_sync.sv
`timescale 1ns/1ns
module pin_sync (
	input wire logic clock,
	input wire logic rst,
	input wire logic pin,
	output logic level
);
	typedef struct packed {
		logic [2:0] stage;
		logic level;
	} sync_state_t;

	sync_state_t state_reg;
	sync_state_t state_next;

	always_comb begin
		state_next = state_reg;
		state_next.stage = {state_reg.stage[1:0], pin};
		// Stage 0 feeds only stage 1; a change counts once stages 1 and 2 agree
		if (state_reg.stage[1] == state_reg.stage[2]) begin
			state_next.level = state_reg.stage[2];
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign level = state_reg.level;
endmodule

// File: hdl/converter_control_regs.sv
`timescale 1ns/1ns
`include "converter_control_cfg.svh"
module converter_control_regs (
	input wire logic clock,
	input wire logic rst,
	input wire converter_control_pkg::reg_req_t req,
	input wire logic req_valid,
	input wire logic enable_pin,
	output logic [7:0] rdata,
	output logic rdata_valid,
	output converter_control_pkg::conv_ctrl_t conv0,
	output converter_control_pkg::conv_ctrl_t conv1,
	output converter_control_pkg::lin_ctrl_t lin0,
	output converter_control_pkg::lin_ctrl_t lin1
);
	import converter_control_pkg::*;

	typedef struct packed {
		logic [7:0] conv0_limit_slew;
		logic [7:0] conv1_control;
		logic [7:0] conv1_limit_slew;
		logic [7:0] conv0_voltage_set;
		logic [7:0] conv1_voltage_set;
		logic [7:0] linreg0_control;
		logic [7:0] linreg1_control;
		logic [7:0] rdata;
		logic rdata_valid;
		conv_ctrl_t conv0;
		conv_ctrl_t conv1;
		lin_ctrl_t lin0;
		lin_ctrl_t lin1;
	} regs_state_t;

	regs_state_t state_reg;
	regs_state_t state_next;
	logic pin_level;

	pin_sync pin_sync_inst (
		.clock(clock),
		.rst(rst),
		.pin(enable_pin),
		.level(pin_level)
	);

	function automatic logic gated_enable(input logic [7:0] ctrl, input logic pin);
		logic on;
		on = ctrl[`TURN_ON_BIT];
		if (ctrl[`PIN_GATING_BIT]) begin
			on = on & pin;
		end
		return on;
	endfunction

	function automatic conv_ctrl_t decode_conv(input logic [7:0] ls, input logic [7:0] volt,
			input logic [7:0] ctrl, input logic pin);
		conv_ctrl_t c;
		c.current_limit = ls[`LIMIT_LSB +: 3];
		c.ramp_code = ls[`RAMP_LSB +: 3];
		c.voltage_code = volt;
		c.force_pulse_width = ctrl[`FORCE_PW_BIT];
		c.discharge_on = ctrl[`DISCHARGE_BIT];
		c.enable = gated_enable(ctrl, pin);
		// Reserved codes are passed through but flagged so the analog side can hold its last good setting
		c.limit_code_ok = (ls[`LIMIT_LSB +: 3] <= `LIMIT_MAX_CODE);
		c.ramp_code_ok = (ls[`RAMP_LSB +: 3] >= `RAMP_MIN_CODE);
		c.voltage_code_ok = (volt >= `VOLT_MIN_CODE);
		return c;
	endfunction

	always_comb begin
		state_next = state_reg;
		state_next.rdata_valid = 1'b0;
		if (req_valid && req.write) begin
			// Any register may change while running; new codes reach the outputs two cycles after the write
			unique case (req.addr)
				`CONV0_LIMIT_SLEW_ADDR: begin
					state_next.conv0_limit_slew = req.wdata;
				end
				`CONV1_CONTROL_ADDR: begin
					state_next.conv1_control = req.wdata;
				end
				`CONV1_LIMIT_SLEW_ADDR: begin
					state_next.conv1_limit_slew = req.wdata;
				end
				`CONV0_VOLTAGE_SET_ADDR: begin
					state_next.conv0_voltage_set = req.wdata;
				end
				`CONV1_VOLTAGE_SET_ADDR: begin
					state_next.conv1_voltage_set = req.wdata;
				end
				`LINREG0_CONTROL_ADDR: begin
					state_next.linreg0_control = req.wdata;
				end
				`LINREG1_CONTROL_ADDR: begin
					state_next.linreg1_control = req.wdata;
				end
				default: begin
					state_next.rdata = state_reg.rdata;
				end
			endcase
		end else if (req_valid) begin
			state_next.rdata_valid = 1'b1;
			// Unmapped addresses read as zero
			unique case (req.addr)
				`CONV0_LIMIT_SLEW_ADDR: state_next.rdata = state_reg.conv0_limit_slew;
				`CONV1_CONTROL_ADDR: state_next.rdata = state_reg.conv1_control;
				`CONV1_LIMIT_SLEW_ADDR: state_next.rdata = state_reg.conv1_limit_slew;
				`CONV0_VOLTAGE_SET_ADDR: state_next.rdata = state_reg.conv0_voltage_set;
				`CONV1_VOLTAGE_SET_ADDR: state_next.rdata = state_reg.conv1_voltage_set;
				`LINREG0_CONTROL_ADDR: state_next.rdata = state_reg.linreg0_control;
				`LINREG1_CONTROL_ADDR: state_next.rdata = state_reg.linreg1_control;
				default: state_next.rdata = 8'h00;
			endcase
		end
		// Converter 0 control-1 is not held here, so it runs from its enable pin alone
		state_next.conv0 = decode_conv(state_reg.conv0_limit_slew, state_reg.conv0_voltage_set,
			8'h00, pin_level);
		state_next.conv0.enable = pin_level;
		state_next.conv0.discharge_on = 1'b1;
		state_next.conv1 = decode_conv(state_reg.conv1_limit_slew, state_reg.conv1_voltage_set,
			state_reg.conv1_control, pin_level);
		state_next.lin0.discharge_on = state_reg.linreg0_control[`DISCHARGE_BIT];
		state_next.lin0.enable = gated_enable(state_reg.linreg0_control, pin_level);
		state_next.lin1.discharge_on = state_reg.linreg1_control[`DISCHARGE_BIT];
		state_next.lin1.enable = gated_enable(state_reg.linreg1_control, pin_level);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= '0;
			state_reg.conv0_limit_slew <= `LIMIT_SLEW_RESET;
			state_reg.conv1_limit_slew <= `LIMIT_SLEW_RESET;
			state_reg.conv1_control <= `CONTROL_RESET;
			state_reg.linreg0_control <= `CONTROL_RESET;
			state_reg.linreg1_control <= `CONTROL_RESET;
			state_reg.conv0_voltage_set <= `VOLTAGE_RESET;
			state_reg.conv1_voltage_set <= `VOLTAGE_RESET;
		end else begin
			state_reg <= state_next;
		end
	end

	assign rdata = state_reg.rdata;
	assign rdata_valid = state_reg.rdata_valid;
	assign conv0 = state_reg.conv0;
	assign conv1 = state_reg.conv1;
	assign lin0 = state_reg.lin0;
	assign lin1 = state_reg.lin1;
endmodule

// File: verif/converter_control_regs_checker.sv
`timescale 1ns/1ns
module converter_control_regs_checker (
	input wire logic clock,
	input wire logic rst,
	input wire converter_control_pkg::reg_req_t req,
	input wire logic req_valid,
	input wire logic enable_pin,
	input wire logic [7:0] rdata,
	input wire logic rdata_valid,
	input wire converter_control_pkg::conv_ctrl_t conv0,
	input wire converter_control_pkg::conv_ctrl_t conv1,
	input wire converter_control_pkg::lin_ctrl_t lin0,
	input wire converter_control_pkg::lin_ctrl_t lin1
);
	import converter_control_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	wire rd = req_valid && !req.write;
	wire wr = req_valid && req.write;
	a_read_answer: assert property (rd |=> rdata_valid) else $error("read unanswered");
	a_valid_cause: assert property (!rd |=> !rdata_valid) else $error("stray read valid");
	a_limit_flag: assert property (!$past(rst) |-> conv1.limit_code_ok == (conv1.current_limit <= 3'h5)) else $error("limit flag");
	a_ramp_flag: assert property (!$past(rst) |-> conv0.ramp_code_ok == (conv0.ramp_code >= 3'h2)) else $error("ramp flag");
	a_volt_flag: assert property (!$past(rst) |-> conv1.voltage_code_ok == (conv1.voltage_code >= 8'h14)) else $error("volt flag");
	a_limit_write: assert property (wr && req.addr == 8'h05 |=> ##1 conv1.current_limit == $past(req.wdata[5:3], 2)
		&& conv1.ramp_code == $past(req.wdata[2:0], 2)) else $error("limit write");
	a_volt_write: assert property (wr && req.addr == 8'h07 |=> ##1 conv1.voltage_code == $past(req.wdata, 2)) else $error("volt write");
	a_mode_write: assert property (wr && req.addr == 8'h04 |=> ##1 conv1.force_pulse_width == $past(req.wdata[3], 2)
		&& conv1.discharge_on == $past(req.wdata[2], 2)) else $error("mode write");
	a_reset_state: assert property ($fell(rst) |=> conv1.discharge_on && lin0.discharge_on && !lin0.enable
		&& !conv1.enable) else $error("reset state");
	c_read: cover property (rd ##1 rdata_valid);
	c_bad_limit: cover property (wr && req.addr == 8'h05 && req.wdata[5:3] > 3'h5);
	c_enabled: cover property (conv1.enable && lin0.enable);
endmodule
bind converter_control_regs converter_control_regs_checker i_chk (.clock(clock), .rst(rst), .req(req),
	.req_valid(req_valid), .enable_pin(enable_pin), .rdata(rdata), .rdata_valid(rdata_valid), .conv0(conv0),
	.conv1(conv1), .lin0(lin0), .lin1(lin1));

// File: verif/converter_control_regs_bench.sv
`timescale 1ns/1ns
module converter_control_regs_bench;
	import converter_control_pkg::*;
	logic clock, rst, req_valid, enable_pin, rdata_valid;
	reg_req_t req;
	logic [7:0] rdata;
	conv_ctrl_t conv0, conv1;
	lin_ctrl_t lin0, lin1;
	logic [7:0] mdl [0:255];
	logic [7:0] bv [6] = '{8'h13, 8'h14, 8'h2b, 8'h31, 8'h9d, 8'hff};
	logic [15:0] seed;
	int error_cnt, n_tests;
	converter_control_regs i_converter_control_regs (.clock(clock), .rst(rst), .req(req), .req_valid(req_valid),
		.enable_pin(enable_pin), .rdata(rdata), .rdata_valid(rdata_valid), .conv0(conv0), .conv1(conv1),
		.lin0(lin0), .lin1(lin1));
	initial begin
		clock = 0;
		forever #2 clock = ~clock;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// Enable follows the pin only when gating is set
	function automatic conv_ctrl_t ex(input logic [7:0] c, input logic [7:0] ls, input logic [7:0] v);
		return {ls[5:3], ls[2:0], v, c[3], c[2], c[0] & (!c[1] | enable_pin), ls[5:3] <= 3'h5, ls[2:0] >= 3'h2,
			v >= 8'h14};
	endfunction
	task automatic cmp(input logic [19:0] got, input logic [19:0] exp);
		n_tests++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Called at a falling edge; valid stays up so calls run back to back
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		req_valid = 1;
		req = '{w, a, d};
		if (w && a >= 8'h03 && a <= 8'h09)
			mdl[a] = d;
		@(negedge clock);
		if (!w)
			cmp({11'h000, rdata_valid, rdata}, {12'h001, mdl[a]});
	endtask
	task automatic idle(input int n);
		req_valid = 0;
		repeat (n) @(negedge clock);
	endtask
	task automatic readall();
		for (int a = 0; a < 12; a++)
			acc(1'b0, a[7:0], 8'h00);
		idle(1);
	endtask
	task automatic chk_out();
		cmp(conv0, ex(8'h07, mdl[3], mdl[6]));
		cmp(conv1, ex(mdl[4], mdl[5], mdl[7]));
		cmp({18'h0_0000, lin0}, {18'h0_0000, mdl[8][2], mdl[8][0] & (!mdl[8][1] | enable_pin)});
		cmp({18'h0_0000, lin1}, {18'h0_0000, mdl[9][2], mdl[9][0] & (!mdl[9][1] | enable_pin)});
	endtask
	task automatic test_done();
		$display("tests %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Far beyond the roughly 500 cycles the sequence needs
	initial begin
		#200000;
		error_cnt++;
		test_done();
	end
	initial begin
		rst = 1;
		req_valid = 0;
		req = '0;
		enable_pin = 0;
		seed = 16'h1a22;
		error_cnt = 0;
		n_tests = 0;
		for (int i = 0; i < 256; i++)
			mdl[i] = 8'h00;
		mdl[4] = 8'h04;
		mdl[8] = 8'h04;
		mdl[9] = 8'h04;
		repeat (12) @(negedge clock);
		rst = 0;
		readall();
		chk_out();
		for (int i = 0; i < 6; i++) begin
			acc(1'b1, 8'h05, bv[i]);
			acc(1'b1, 8'h07, bv[i]);
			acc(1'b1, 8'h03, bv[i]);
			acc(1'b1, 8'h06, bv[i]);
			idle(2);
			chk_out();
		end
		// Pin held steady long enough to clear the synchronizer
		for (int r = 0; r < 30; r++) begin
			seed = lfsr(seed);
			enable_pin = seed[0];
			repeat (6) begin
				seed = lfsr(seed);
				acc(1'b1, 8'h03 + {5'h00, seed[2:0]}, seed[15:8]);
			end
			idle(8);
			chk_out();
		end
		readall();
		test_done();
	end
endmodule
